// ### pkg/adcs_pkg.sv
package adcs_pkg;
    // oscillator tick derived from the system clock
    localparam int SYS_PERIOD_NS = 50;
    localparam int OSC_PERIOD_NS = 200;
    localparam int OSC_DIV = (OSC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV - 1);

    // data output release window, in osc periods
    localparam logic [3:0] DOUT_REL_MIN_OSC = 4'h6;
    localparam logic [3:0] DOUT_REL_MAX_OSC = 4'hA;
    localparam logic [3:0] DOUT_REL_OSC = 4'h8;
    localparam logic [3:0] IDLE_SAT = 4'hF;

    // gaps, in osc periods
    localparam logic [11:0] CMD_GAP_OSC = 12'h004;

    // result update hold, in osc periods and in system cycles
    localparam logic [2:0] UPDATE_HOLD_OSC = 3'h4;
    localparam int UPDATE_HOLD_CYC = 4 * OSC_DIV;
    localparam logic [4:0] RDY_HI_SAT = 5'h1F;

    // clock reset pattern windows, in osc periods
    localparam logic [10:0] RST_HI1_MIN = 11'h12C;
    localparam logic [10:0] RST_HI1_MAX = 11'h1F4;
    localparam logic [10:0] RST_HI2_MIN = 11'h226;
    localparam logic [10:0] RST_HI2_MAX = 11'h2EE;
    localparam logic [10:0] RST_HI3_MIN = 11'h41A;
    localparam logic [10:0] RST_HI3_MAX = 11'h4E2;
    localparam logic [10:0] RST_HI_SAT = 11'h7FF;
    localparam logic [2:0] RST_LO_MIN = 3'h5;
    localparam logic [2:0] RST_LO_SAT = 3'h7;

    // serial framing
    localparam logic [4:0] BYTE_LAST = 5'h07;
    localparam logic [4:0] RESULT_LAST = 5'h17;

    // input selector: channels 0..7 plus the common input
    localparam logic [3:0] MUX_LAST = 4'h8;
    localparam logic [3:0] MUX_POS_RST = 4'h0;
    localparam logic [3:0] MUX_NEG_RST = 4'h8;

    // command codes
    localparam logic [7:0] READ_RESULT_CMD = 8'h01;
    localparam logic [7:0] READ_CONFIG_CMD = 8'h10;
    localparam logic [7:0] WRITE_CONFIG_CMD = 8'h50;
    localparam logic [7:0] RESET_CMD = 8'hFE;

    // command sequencer states
    typedef enum logic [3:0] {
        ST_CMD = 4'h1,
        ST_WDATA = 4'h2,
        ST_RDATA = 4'h4,
        ST_GAP = 4'h8
    } adcs_state_t;
endpackage : adcs_pkg

// ### hw/adcs_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for pins from outside the clock domain
module adcs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first flop feeds only the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : adcs_sync

// ### hw/adcs_top.sv
`timescale 1ns/10ps
// serial command interface of the converter, device side
module adcs_top
    import adcs_pkg::*;
#(
    parameter int CONV_PERIOD_OSC = 4096,
    parameter int RESET_GAP_OSC = 2640
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial pins
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic ser_din,
    output logic ser_dout,
    output logic ser_dout_oe,
    output logic result_ready_n,
    // converter core
    input wire logic [23:0] conv_data,
    output logic [3:0] mux_pos_sel,
    output logic [3:0] mux_neg_sel,
    output logic soft_reset
);
    localparam logic [15:0] CONV_LAST = 16'(CONV_PERIOD_OSC - 1);
    localparam logic [2:0] HOLD_LAST = UPDATE_HOLD_OSC - 3'h1;

    logic [2:0] pins_s;
    logic cs_n_s, sclk_s, din_s, sclk_prev_q, sclk_rise, sclk_fall;
    logic [2:0] osc_div_q;
    logic osc_tick;
    logic [3:0] idle_osc_q;
    adcs_state_t state_q;
    logic [11:0] gap_q;
    logic [4:0] bit_cnt_q, rd_last_q;
    logic [7:0] shift_in_q, cmd_byte;
    logic [22:0] shift_out_q;
    logic byte_end, rd_result, rd_config, reset_hit, wr_done;
    logic [15:0] conv_cnt_q;
    logic [2:0] hold_q;
    logic updating_q, upd, upd_start;
    logic [23:0] result_q;
    logic [4:0] rdy_hi_cnt_q;
    logic [10:0] hi_osc_q;
    logic [2:0] lo_osc_q;
    logic [1:0] stage_q;
    logic hi1_ok, hi2_ok, hi3_ok, pat_hit;

    // pins pass two flops
    adcs_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({chip_sel_n, ser_clk, ser_din}),
        .q(pins_s)
    );
    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    // serial clock edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // oscillator period tick
    always_ff @(posedge sys_clk) begin
        if (rst || osc_div_q == OSC_DIV_LAST) begin
            osc_div_q <= 3'h0;
        end else begin
            osc_div_q <= osc_div_q + 3'h1;
        end
    end
    assign osc_tick = (osc_div_q == OSC_DIV_LAST);

    // osc periods since the last serial clock edge
    always_ff @(posedge sys_clk) begin
        if (rst || sclk_rise || sclk_fall) begin
            idle_osc_q <= 4'h0;
        end else if (osc_tick && idle_osc_q != IDLE_SAT) begin
            idle_osc_q <= idle_osc_q + 4'h1;
        end
    end

    // command decode terms
    assign cmd_byte = {shift_in_q[6:0], din_s};
    assign byte_end = !cs_n_s && sclk_rise && bit_cnt_q == BYTE_LAST;
    assign rd_result = state_q == ST_CMD && byte_end
        && cmd_byte == READ_RESULT_CMD;
    assign rd_config = state_q == ST_CMD && byte_end
        && cmd_byte == READ_CONFIG_CMD;
    assign reset_hit = state_q == ST_CMD && byte_end && cmd_byte == RESET_CMD;
    assign wr_done = state_q == ST_WDATA && byte_end;

    // command sequencer; edges inside a gap are ignored
    always_ff @(posedge sys_clk) begin
        if (rst || soft_reset) begin
            state_q <= ST_GAP;
            gap_q <= 12'(RESET_GAP_OSC);
            bit_cnt_q <= 5'h00;
            shift_in_q <= 8'h00;
            rd_last_q <= BYTE_LAST;
        end else begin
            case (state_q)
                ST_CMD: begin
                    if (cs_n_s) begin
                        bit_cnt_q <= 5'h00;
                    end else if (sclk_rise) begin
                        shift_in_q <= cmd_byte;
                        bit_cnt_q <= byte_end ? 5'h00 : bit_cnt_q + 5'h01;
                        if (byte_end) begin
                            if (rd_result) begin
                                state_q <= ST_RDATA;
                                rd_last_q <= RESULT_LAST;
                            end else if (rd_config) begin
                                state_q <= ST_RDATA;
                                rd_last_q <= BYTE_LAST;
                            end else if (cmd_byte == WRITE_CONFIG_CMD) begin
                                state_q <= ST_WDATA;
                            end else begin
                                state_q <= ST_GAP;
                                gap_q <= CMD_GAP_OSC;
                            end
                        end
                    end
                end
                ST_WDATA: begin
                    if (cs_n_s) begin
                        state_q <= ST_CMD;
                        bit_cnt_q <= 5'h00;
                    end else if (sclk_rise) begin
                        shift_in_q <= cmd_byte;
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                        if (byte_end) begin
                            state_q <= ST_GAP;
                            gap_q <= CMD_GAP_OSC;
                        end
                    end
                end
                ST_RDATA: begin
                    if (cs_n_s) begin
                        state_q <= ST_CMD;
                        bit_cnt_q <= 5'h00;
                    end else if (sclk_rise) begin
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                        if (bit_cnt_q == rd_last_q) begin
                            state_q <= ST_GAP;
                            gap_q <= CMD_GAP_OSC;
                        end
                    end
                end
                ST_GAP: begin
                    bit_cnt_q <= 5'h00;
                    if (osc_tick) begin
                        if (gap_q == 12'h000) begin
                            state_q <= ST_CMD;
                        end else begin
                            gap_q <= gap_q - 12'h001;
                        end
                    end
                end
                default: state_q <= ST_CMD;
            endcase
        end
    end

    // output shifter: first bit at decode, next on each falling edge but the one ending the command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ser_dout <= 1'b0;
            shift_out_q <= 23'h000000;
        end else if (rd_result) begin
            ser_dout <= result_q[23];
            shift_out_q <= result_q[22:0];
        end else if (rd_config) begin
            ser_dout <= mux_pos_sel[3];
            shift_out_q <= {mux_pos_sel[2:0], mux_neg_sel, 16'h0000};
        end else if (state_q == ST_RDATA && sclk_fall && bit_cnt_q != 5'h00)
        begin
            ser_dout <= shift_out_q[22];
            shift_out_q <= {shift_out_q[21:0], 1'b0};
        end
    end

    // output drive: off at once on deselect, else 8 osc after last edge outside ST_RDATA
    always_ff @(posedge sys_clk) begin
        if (rst || soft_reset || cs_n_s) begin
            ser_dout_oe <= 1'b0;
        end else if (rd_result || rd_config) begin
            ser_dout_oe <= 1'b1;
        end else if (state_q != ST_RDATA && idle_osc_q == DOUT_REL_OSC) begin
            ser_dout_oe <= 1'b0;
        end
    end

    // input selector; equal or out-of-range pairs are refused
    always_ff @(posedge sys_clk) begin
        if (rst || soft_reset) begin
            mux_pos_sel <= MUX_POS_RST;
            mux_neg_sel <= MUX_NEG_RST;
        end else if (wr_done && cmd_byte[7:4] <= MUX_LAST
            && cmd_byte[3:0] <= MUX_LAST && cmd_byte[7:4] != cmd_byte[3:0])
        begin
            mux_pos_sel <= cmd_byte[7:4];
            mux_neg_sel <= cmd_byte[3:0];
        end
    end

    // conversion period and update hold
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conv_cnt_q <= 16'h0000;
            hold_q <= 3'h0;
            updating_q <= 1'b0;
        end else if (osc_tick) begin
            if (updating_q) begin
                hold_q <= (hold_q == HOLD_LAST) ? 3'h0 : hold_q + 3'h1;
                updating_q <= (hold_q != HOLD_LAST);
            end else if (conv_cnt_q == CONV_LAST) begin
                conv_cnt_q <= 16'h0000;
                updating_q <= 1'b1;
            end else begin
                conv_cnt_q <= conv_cnt_q + 16'h0001;
            end
        end
    end
    assign upd = osc_tick && updating_q && hold_q == HOLD_LAST;
    assign upd_start = osc_tick && !updating_q && conv_cnt_q == CONV_LAST;

    // result register and ready flag; ready rises with the hold start
    // so that it stands high for the whole hold, not one cycle short
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= 24'h000000;
            result_ready_n <= 1'b1;
        end else if (upd) begin
            result_q <= conv_data;
            result_ready_n <= 1'b0;
        end else if (upd_start || updating_q || rd_result) begin
            result_ready_n <= 1'b1;
        end
    end

    // clock reset pattern: pulse lengths in osc periods
    always_ff @(posedge sys_clk) begin
        if (rst || sclk_rise) begin
            hi_osc_q <= 11'h000;
        end else if (sclk_s && osc_tick && hi_osc_q != RST_HI_SAT) begin
            hi_osc_q <= hi_osc_q + 11'h001;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || sclk_fall) begin
            lo_osc_q <= 3'h0;
        end else if (!sclk_s && osc_tick && lo_osc_q != RST_LO_SAT) begin
            lo_osc_q <= lo_osc_q + 3'h1;
        end
    end
    assign hi1_ok = hi_osc_q >= RST_HI1_MIN && hi_osc_q <= RST_HI1_MAX;
    assign hi2_ok = hi_osc_q >= RST_HI2_MIN && hi_osc_q <= RST_HI2_MAX;
    assign hi3_ok = hi_osc_q >= RST_HI3_MIN && hi_osc_q <= RST_HI3_MAX;
    assign pat_hit = sclk_fall && stage_q == 2'h2 && hi3_ok;

    // pattern stage: pulses seen in order
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage_q <= 2'h0;
        end else if (sclk_rise && lo_osc_q < RST_LO_MIN) begin
            stage_q <= 2'h0;
        end else if (sclk_fall) begin
            if (stage_q == 2'h0 && hi1_ok) begin
                stage_q <= 2'h1;
            end else if (stage_q == 2'h1 && hi2_ok) begin
                stage_q <= 2'h2;
            end else begin
                stage_q <= 2'h0;
            end
        end
    end

    // soft reset from command or clock pattern
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= pat_hit || reset_hit;
        end
    end

    // cycles the ready flag has stood high, for checking only
    always_ff @(posedge sys_clk) begin
        if (rst || !result_ready_n) begin
            rdy_hi_cnt_q <= 5'h00;
        end else if (rdy_hi_cnt_q != RDY_HI_SAT) begin
            rdy_hi_cnt_q <= rdy_hi_cnt_q + 5'h01;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_dout_deselect: assert property (cs_n_s |=> !ser_dout_oe)
        else $error("data output still driven after deselect");
    a_dout_release: assert property (($fell(ser_dout_oe)
        && !$past(cs_n_s) && !$past(soft_reset))
        |-> $past(idle_osc_q) >= DOUT_REL_MIN_OSC
        && $past(idle_osc_q) <= DOUT_REL_MAX_OSC)
        else $error("data output released outside its window");
    a_ready_hold: assert property (upd |-> result_ready_n
        && rdy_hi_cnt_q >= 5'(UPDATE_HOLD_CYC - 1))
        else $error("ready flag high too briefly before update");
    a_ready_low_new: assert property (upd |=> !result_ready_n
        && result_q == $past(conv_data))
        else $error("new result not flagged");
    a_mux_distinct: assert property (mux_pos_sel != mux_neg_sel
        && mux_pos_sel <= MUX_LAST && mux_neg_sel <= MUX_LAST)
        else $error("input selector pair invalid");
    a_pattern_first: assert property ((sclk_fall && stage_q == 2'h0
        && hi1_ok && !(sclk_rise && lo_osc_q < RST_LO_MIN))
        |=> stage_q == 2'h1)
        else $error("first reset pulse not accepted");
    a_pattern_fire: assert property ((sclk_fall && stage_q == 2'h2
        && hi3_ok) |=> soft_reset ##1 state_q == ST_GAP)
        else $error("clock reset pattern did not reset");
    a_gap_ignore: assert property ((state_q == ST_GAP && !osc_tick)
        |=> state_q == ST_GAP)
        else $error("command accepted inside gap");

    c_soft_reset: cover property (pat_hit);
    c_result_read: cover property (rd_result ##[1:1000] $fell(ser_dout_oe));
    c_mux_write: cover property (wr_done);
    c_update: cover property (upd);
endmodule : adcs_top

// ### test/adcs_host.sv
`timescale 1ns/10ps
// host controller model driving the serial pins of the converter
module adcs_host #(
    parameter int H = 8
) (
    // clock
    input wire logic sys_clk,
    // serial pins
    output logic chip_sel_n,
    output logic ser_clk,
    output logic ser_din,
    input wire logic ser_dout
);
    logic idle_q = 1'b1;

    // pins idle at time zero
    initial begin
        chip_sel_n = 1'b1;
        ser_clk = 1'b0;
        ser_din = 1'b0;
    end

    // released data line toggles so no stale bit can be taken
    always @(posedge sys_clk) begin
        if (idle_q) ser_din <= ~ser_din;
    end

    // select or release the device, select is active low
    task automatic sel(input logic on);
        @(posedge sys_clk);
        chip_sel_n <= ~on;
        idle_q = ~on;
    endtask : sel

    // wait whole oscillator periods of four system cycles
    task automatic wait_osc(input int n);
        repeat (n * 4) @(posedge sys_clk);
    endtask : wait_osc

    // one byte msb first, clock period 2*H cycles
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            ser_din <= b[i];
            repeat (H - 1) @(posedge sys_clk);
            ser_clk <= 1'b1;
            repeat (H) @(posedge sys_clk);
            ser_clk <= 1'b0;
        end
    endtask : put_byte

    // clock n bits out, ends on the last falling edge
    task automatic get_bits(input int n, output logic [23:0] v);
        v = 24'h000000;
        for (int i = 0; i < n; i++) begin
            repeat (H) @(posedge sys_clk);
            v = {v[22:0], ser_dout};
            ser_clk <= 1'b1;
            repeat (H) @(posedge sys_clk);
            ser_clk <= 1'b0;
        end
    endtask : get_bits

    // one high pulse and low interval of the clock reset pattern
    task automatic pulse(input int hi, input int lo);
        @(posedge sys_clk);
        ser_clk <= 1'b1;
        repeat (hi * 4 - 1) @(posedge sys_clk);
        ser_clk <= 1'b0;
        repeat (lo * 4 - 1) @(posedge sys_clk);
    endtask : pulse
endmodule : adcs_host

// ### test/tb_adcs_top.sv
`timescale 1ns/10ps
// bench for the serial command interface
module tb_adcs_top;
    import adcs_pkg::*;
    localparam int CONV = 200;
    localparam int RGAP = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic chip_sel_n, ser_clk, ser_din, ser_dout, ser_dout_oe;
    logic result_ready_n, soft_reset;
    logic [23:0] conv_data;
    logic [23:0] exp_res, rd;
    logic [3:0] mux_pos_sel, mux_neg_sel;
    int error_cnt = 0;
    int n_checks = 0;
    int sr_cnt = 0;
    int exp_pos = 0;
    int exp_neg = 8;
    int n, s, p, q;

    always #25 sys_clk = ~sys_clk;

    // count soft reset pulses
    always @(posedge sys_clk) begin
        if (soft_reset === 1'b1) sr_cnt++;
    end

    adcs_top #(.CONV_PERIOD_OSC(CONV), .RESET_GAP_OSC(RGAP)) i_adcs_top (
        .sys_clk(sys_clk), .rst(rst), .chip_sel_n(chip_sel_n),
        .ser_clk(ser_clk), .ser_din(ser_din), .ser_dout(ser_dout),
        .ser_dout_oe(ser_dout_oe), .result_ready_n(result_ready_n),
        .conv_data(conv_data), .mux_pos_sel(mux_pos_sel),
        .mux_neg_sel(mux_neg_sel), .soft_reset(soft_reset));

    adcs_host i_adcs_host (
        .sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .ser_clk(ser_clk),
        .ser_din(ser_din), .ser_dout(ser_dout));

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // compare a design value
    task automatic chk_val(string nm, logic [23:0] e, logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    // compare a count against a range
    task automatic chk_rng(string nm, int lo, int hi, int g);
        n_checks++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    // bounded wait for a result ready level
    task automatic wait_rdy(input logic lvl);
        int i;
        for (i = 0; i < 2000 && result_ready_n !== lvl; i++)
            @(posedge sys_clk);
        if (i == 2000) begin
            error_cnt++;
            $display("FAIL ready_wait expected %b seen timeout", lvl);
            summarize();
        end
    endtask : wait_rdy

    // cycles until a signal leaves a level, bounded
    task automatic cnt_while(ref logic sig, input logic lvl, output int c);
        for (c = 0; c < 100 && sig === lvl; c++) @(posedge sys_clk);
    endtask : cnt_while

    // send a command of nb bytes and clock nr bits back
    task automatic do_cmd(input logic [15:0] b, input int nb, input int nr);
        i_adcs_host.sel(1'b1);
        i_adcs_host.put_byte(b[15:8]);
        if (nb == 2) i_adcs_host.put_byte(b[7:0]);
        if (nr > 0) begin
            i_adcs_host.wait_osc(50);
            i_adcs_host.get_bits(nr, rd);
        end
    endtask : do_cmd

    // release the device and keep the command gap
    task automatic fin();
        i_adcs_host.sel(1'b0);
        i_adcs_host.wait_osc(6);
    endtask : fin

    // write the selector pair, check the pins and read it back
    task automatic cfg(input int a, input int c);
        do_cmd({WRITE_CONFIG_CMD, 4'(a), 4'(c)}, 2, 0);
        fin();
        if (a != c && a <= 8 && c <= 8) begin
            exp_pos = a;
            exp_neg = c;
        end
        chk_val("mux_pos", 24'(exp_pos), 24'(mux_pos_sel));
        chk_val("mux_neg", 24'(exp_neg), 24'(mux_neg_sel));
        do_cmd({READ_CONFIG_CMD, 8'h00}, 1, 8);
        fin();
        chk_val("cfg_read", 24'({4'(exp_pos), 4'(exp_neg)}), rd);
    endtask : cfg

    // check selector pins against the model
    task automatic chk_mux();
        chk_val("mux_pos", 24'(exp_pos), 24'(mux_pos_sel));
        chk_val("mux_neg", 24'(exp_neg), 24'(mux_neg_sel));
    endtask : chk_mux

    // watchdog
    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        $display("FAIL run expected end seen timeout");
        summarize();
    end

    // main sequence
    initial begin
        void'($urandom(3));
        conv_data <= 24'($urandom());
        repeat (10) @(posedge sys_clk);
        chk_val("oe_rst", 24'h0, 24'(ser_dout_oe));
        chk_val("rdy_rst", 24'h1, 24'(result_ready_n));
        chk_val("sr_rst", 24'h0, 24'(soft_reset));
        chk_mux();
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        i_adcs_host.wait_osc(RGAP + 4);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            exp_res = (k == 0) ? 24'hFFFFFF : 24'($urandom());
            conv_data <= exp_res;
            wait_rdy(1'b1);
            wait_rdy(1'b0);
            chk_val("rdy_low", 24'h0, 24'(result_ready_n));
            do_cmd({READ_RESULT_CMD, 8'h00}, 1, 24);
            cnt_while(ser_dout_oe, 1'b1, n);
            chk_rng("dout_release", 24, 40, n);
            chk_val("result", exp_res, rd);
            fin();
        end
        $display("test result read done");
        for (int k = 0; k < 3; k++) begin
            p = $urandom_range(8);
            q = (p + 1 + $urandom_range(7)) % 9;
            cfg(p, q);
        end
        cfg(exp_neg, exp_neg);
        cfg(9, 2);
        $display("test selector done");
        // start from a low flag so the whole high pulse is counted
        for (int k = 0; k < 2; k++) begin
            wait_rdy(1'b0);
            wait_rdy(1'b1);
            cnt_while(result_ready_n, 1'b1, n);
            chk_rng("rdy_high", 16, 20, n);
        end
        $display("test ready pulse done");
        do_cmd({READ_RESULT_CMD, 8'h00}, 1, 4);
        chk_val("oe_mid", 24'h1, 24'(ser_dout_oe));
        i_adcs_host.sel(1'b0);
        cnt_while(ser_dout_oe, 1'b1, n);
        chk_rng("cs_release", 1, 5, n);
        i_adcs_host.wait_osc(6);
        $display("test abort done");
        s = sr_cnt;
        do_cmd({RESET_CMD, 8'h00}, 1, 0);
        fin();
        chk_rng("cmd_reset", s + 1, s + 1, sr_cnt);
        exp_pos = 0;
        exp_neg = 8;
        chk_mux();
        i_adcs_host.wait_osc(RGAP + 4);
        cfg(6, 1);
        $display("test reset command done");
        s = sr_cnt;
        i_adcs_host.pulse(310, 10);
        i_adcs_host.pulse(740, 10);
        i_adcs_host.pulse(1060, 10);
        chk_rng("pattern_reset", s + 1, s + 1, sr_cnt);
        exp_pos = 0;
        exp_neg = 8;
        chk_mux();
        i_adcs_host.wait_osc(RGAP + 4);
        s = sr_cnt;
        i_adcs_host.pulse(280, 10);
        i_adcs_host.pulse(650, 10);
        i_adcs_host.pulse(1150, 10);
        chk_rng("short_first", s, s, sr_cnt);
        $display("test clock pattern done");
        summarize();
    end
endmodule : tb_adcs_top
